// >>> verilog/swsl_top.v
// Stop-mode wake-up source logic with AXI4-Lite register access
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "swsl_defines.vh"
module swsl_top #(
  parameter ADDR_W = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] port2_pins,
  input wire [3:0] port3_pins,
  input wire [1:0] port0_pins,
  input wire [7:0] port2_mode_reg,
  input wire [1:0] port0_input_mask,
  input wire port2_data_reg_read,
  input wire port2_data_reg_write,
  input wire [7:0] port2_data_reg_value,
  input wire port3_data_reg_read,
  input wire port3_data_reg_write,
  input wire [3:0] port3_data_reg_value,
  output reg wake_request,
  output reg ext_interrupt_line_one
);

  // Configuration and status held across stop recovery
  reg [7:0] wake_port2_select;
  reg [3:0] wake_port3_select;
  reg [2:0] combo_src;
  reg combo_level;
  reg irq_enable;
  reg [1:0] p2_status;
  reg [1:0] p3_status;
  reg [7:0] p2_ref;
  reg [3:0] p3_ref;

  // Bus slave state
  reg aw_full;
  reg w_full;
  reg [ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire [13:0] pins_sync;
  wire [7:0] p2s;
  wire [3:0] p3s;
  wire [1:0] p0s;

  // Returns {hit, id} for a byte address
  function [2:0] reg_decode;
    input [ADDR_W-1:0] addr;
    begin
      if (addr[1:0] != 2'h0 || addr[ADDR_W-1:14] != 0)
        reg_decode = 3'h0;
      else if (addr[13:2] == `SWSL_IDX_STATUS)
        reg_decode = {1'b1, `SWSL_ID_STATUS};
      else if (addr[13:2] == `SWSL_IDX_PORT2_SEL)
        reg_decode = {1'b1, `SWSL_ID_PORT2_SEL};
      else if (addr[13:2] == `SWSL_IDX_COMBO)
        reg_decode = {1'b1, `SWSL_ID_COMBO};
      else if (addr[13:2] == `SWSL_IDX_PORT3_SEL)
        reg_decode = {1'b1, `SWSL_ID_PORT3_SEL};
      else
        reg_decode = 3'h0;
    end
  endfunction

  // Comparison wake for one port: low level by default, else change
  function [7:0] pin_wake;
    input [7:0] sel;
    input [7:0] pins;
    input [7:0] ref_val;
    input [1:0] status;
    begin
      if (status == `SWSL_REF_NONE)
        pin_wake = sel & ~pins;
      else
        pin_wake = sel & (pins ^ ref_val);
    end
  endfunction

  swsl_sync #(
    .WIDTH(14)
  ) i_swsl_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({port0_pins, port3_pins, port2_pins}),
    .sync_out(pins_sync)
  );

  assign p2s = pins_sync[7:0];
  assign p3s = pins_sync[11:8];
  assign p0s = pins_sync[13:12];

  wire [2:0] wr_dec = reg_decode(aw_addr);
  wire [2:0] rd_dec = reg_decode(s_axi_araddr);
  wire do_write = aw_full & w_full & ~s_axi_bvalid;
  wire wr_lane0 = do_write & wr_dec[2] & w_strb[0];
  wire wr_status = wr_lane0 & (wr_dec[1:0] == `SWSL_ID_STATUS);
  wire wr_p2sel = wr_lane0 & (wr_dec[1:0] == `SWSL_ID_PORT2_SEL);
  wire wr_combo = wr_lane0 & (wr_dec[1:0] == `SWSL_ID_COMBO);
  wire wr_p3sel = wr_lane0 & (wr_dec[1:0] == `SWSL_ID_PORT3_SEL);

  // Write address and data channels, taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SWSL_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      else if (!aw_full && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      else if (!w_full && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (do_write)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_dec[2] ? `SWSL_RESP_OKAY : `SWSL_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel; select and combination registers read as zero
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SWSL_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= rd_dec[2] ? `SWSL_RESP_OKAY : `SWSL_RESP_SLVERR;
      if (rd_dec == {1'b1, `SWSL_ID_STATUS})
        s_axi_rdata <= {27'h0000000, irq_enable, p3_status, p2_status};
      else
        s_axi_rdata <= 32'h00000000;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // Configuration registers; only aresetn clears them
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wake_port2_select <= `SWSL_RST_PORT2_SEL;
      wake_port3_select <= `SWSL_RST_PORT3_SEL;
      combo_src <= `SWSL_RST_COMBO_SRC;
      combo_level <= `SWSL_RST_COMBO_LEVEL;
      irq_enable <= 1'b0;
    end
    else
    begin
      if (wr_p2sel)
        wake_port2_select <= w_data[7:0];
      // Upper select bits are reserved and not stored
      if (wr_p3sel)
        wake_port3_select <= w_data[3:0];
      // Reserved bits 7, 5, 1:0 are dropped
      if (wr_combo)
      begin
        combo_src <= w_data[`SWSL_COMBO_SRC_HI:`SWSL_COMBO_SRC_LO];
        combo_level <= w_data[`SWSL_COMBO_LEVEL];
      end
      if (wr_status)
        irq_enable <= w_data[`SWSL_STAT_IRQ_EN];
    end
  end

  // Reference latches and status; a port access wins over a clear
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      p2_status <= `SWSL_REF_NONE;
      p3_status <= `SWSL_REF_NONE;
      p2_ref <= 8'h00;
      p3_ref <= 4'h0;
    end
    else
    begin
      if (port2_data_reg_write)
      begin
        p2_ref <= port2_data_reg_value;
        p2_status <= `SWSL_REF_WRITE;
      end
      else if (port2_data_reg_read)
      begin
        p2_ref <= port2_data_reg_value;
        p2_status <= `SWSL_REF_READ;
      end
      else if (wr_status)
        p2_status <= w_data[`SWSL_STAT_P2_HI:`SWSL_STAT_P2_LO];
      if (port3_data_reg_write)
      begin
        p3_ref <= port3_data_reg_value;
        p3_status <= `SWSL_REF_WRITE;
      end
      else if (port3_data_reg_read)
      begin
        p3_ref <= port3_data_reg_value;
        p3_status <= `SWSL_REF_READ;
      end
      else if (wr_status)
        p3_status <= w_data[`SWSL_STAT_P3_HI:`SWSL_STAT_P3_LO];
    end
  end

  // Per-pin comparison events
  wire [7:0] p2_events;
  wire [7:0] p3_events_w;
  assign p2_events = pin_wake(wake_port2_select, p2s, p2_ref, p2_status);
  assign p3_events_w = pin_wake({4'h0, wake_port3_select}, {4'h0, p3s},
    {4'h0, p3_ref}, p3_status);

  // Pins free for the combination logic
  wire [7:0] p2_free = port2_mode_reg & ~wake_port2_select;
  wire [2:0] p3_free = ~wake_port3_select[3:1];
  wire [1:0] p0_free = port0_input_mask;

  reg [7:0] grp_val;
  reg [7:0] grp_use;
  reg grp_nand;
  reg grp_on;
  reg combo_out;
  reg combo_event;

  // Ignored pins are neutral: one for NAND, zero for NOR
  always @*
  begin
    grp_val = 8'h00;
    grp_use = 8'h00;
    grp_nand = 1'b0;
    grp_on = 1'b1;
    case (combo_src)
      `SWSL_SRC_NONE:
        grp_on = 1'b0;
      `SWSL_SRC_NAND_P2:
      begin
        grp_val = {4'h0, p2s[3:0]};
        grp_use = {4'h0, p2_free[3:0]};
        grp_nand = 1'b1;
      end
      `SWSL_SRC_NOR_P2:
      begin
        grp_val = {4'h0, p2s[3:0]};
        grp_use = {4'h0, p2_free[3:0]};
      end
      `SWSL_SRC_NAND_P3:
      begin
        grp_val = {5'h00, p3s[3:1]};
        grp_use = {5'h00, p3_free};
        grp_nand = 1'b1;
      end
      `SWSL_SRC_NOR_P3:
      begin
        grp_val = {5'h00, p3s[3:1]};
        grp_use = {5'h00, p3_free};
      end
      `SWSL_SRC_NOR_P3_P0:
      begin
        grp_val = {3'h0, p3s[3:1], p0s};
        grp_use = {3'h0, p3_free, p0_free};
      end
      `SWSL_SRC_NAND_P3_P0:
      begin
        grp_val = {3'h0, p3s[3:1], p0s};
        grp_use = {3'h0, p3_free, p0_free};
        grp_nand = 1'b1;
      end
      `SWSL_SRC_NAND_P3_P2:
      begin
        grp_val = {2'h0, p3s[3:1], p2s[2:0]};
        grp_use = {2'h0, p3_free, p2_free[2:0]};
        grp_nand = 1'b1;
      end
      default:
        grp_on = 1'b0;
    endcase
    if (grp_nand)
      combo_out = ~&(grp_val | ~grp_use);
    else
      combo_out = ~|(grp_val & grp_use);
    // A group with every pin ignored raises nothing
    combo_event = grp_on & (|grp_use) & (combo_out == combo_level);
  end

  wire any_wake = (|p2_events) | (|p3_events_w[3:0]) | combo_event;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wake_request <= 1'b0;
      ext_interrupt_line_one <= 1'b0;
    end
    else
    begin
      wake_request <= any_wake;
      ext_interrupt_line_one <= any_wake & irq_enable;
    end
  end

endmodule // swsl_top

// >>> verilog/swsl_defines.vh
// Constants for the stop-mode wake-up source logic
`ifndef SWSL_DEFINES_VH
`define SWSL_DEFINES_VH

// Register indices; the bus byte address is four times the index
`define SWSL_IDX_STATUS 12'hF0A
`define SWSL_IDX_PORT2_SEL 12'hF0C
`define SWSL_IDX_COMBO 12'hF0D
`define SWSL_IDX_PORT3_SEL 12'hF0E

// Register ids after decode
`define SWSL_ID_STATUS 2'h0
`define SWSL_ID_PORT2_SEL 2'h1
`define SWSL_ID_COMBO 2'h2
`define SWSL_ID_PORT3_SEL 2'h3

// Reset values
`define SWSL_RST_STATUS 5'h00
`define SWSL_RST_PORT2_SEL 8'h00
`define SWSL_RST_PORT3_SEL 4'h0
`define SWSL_RST_COMBO_SRC 3'h0
`define SWSL_RST_COMBO_LEVEL 1'h0

// Field positions in the status register
`define SWSL_STAT_IRQ_EN 4
`define SWSL_STAT_P3_HI 3
`define SWSL_STAT_P3_LO 2
`define SWSL_STAT_P2_HI 1
`define SWSL_STAT_P2_LO 0

// Field positions in the combination register
`define SWSL_COMBO_LEVEL 6
`define SWSL_COMBO_SRC_HI 4
`define SWSL_COMBO_SRC_LO 2

// Reference source codes
`define SWSL_REF_NONE 2'h0
`define SWSL_REF_READ 2'h1
`define SWSL_REF_WRITE 2'h2

// Combination source codes
`define SWSL_SRC_NONE 3'h0
`define SWSL_SRC_NAND_P2 3'h1
`define SWSL_SRC_NOR_P2 3'h2
`define SWSL_SRC_NAND_P3 3'h3
`define SWSL_SRC_NOR_P3 3'h4
`define SWSL_SRC_NOR_P3_P0 3'h5
`define SWSL_SRC_NAND_P3_P0 3'h6
`define SWSL_SRC_NAND_P3_P2 3'h7

// AXI responses
`define SWSL_RESP_OKAY 2'h0
`define SWSL_RESP_SLVERR 2'h2

`endif

// >>> verilog/swsl_sync.v
// Two-stage synchroniser for the wake pin inputs
`timescale 1ns/1ps
module swsl_sync #(
  parameter WIDTH = 14
) (
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // swsl_sync

// >>> sim/swsl_checker.sv
// Concurrent checks on the wake-up source logic ports
`timescale 1ns/1ps
module swsl_checker (
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic [7:0] port2_pins,
  input logic [3:0] port3_pins,
  input logic [1:0] port0_pins,
  input logic port2_data_reg_read,
  input logic port2_data_reg_write,
  input logic port3_data_reg_read,
  input logic port3_data_reg_write,
  input logic [7:0] port2_mode_reg,
  input logic [1:0] port0_input_mask,
  input logic wake_request,
  input logic ext_interrupt_line_one
);
  // Mode inputs reach the combination logic directly, so they count too
  wire [27:0] inp = {port2_pins, port3_pins, port0_pins, port2_data_reg_read,
    port2_data_reg_write, port3_data_reg_read, port3_data_reg_write,
    port2_mode_reg, port0_input_mask};
  logic [27:0] prev;
  logic [2:0] quiet;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Pin path is three flops deep, so five quiet cycles leave margin
  always @(posedge aclk)
  begin
    prev <= inp;
    if (!aresetn || inp != prev || s_axi_wvalid)
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  end
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");
  property p_wlat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready ##1 s_axi_bvalid;
  endproperty
  a_wlat: assert property (p_wlat) else $error("write answer late");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy: assert property (p_busy) else $error("write taken while busy");
  property p_irq;
    ext_interrupt_line_one |-> wake_request;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without wake");
  property p_quiet;
    quiet > 3'h4 |-> $stable(wake_request) && $stable(ext_interrupt_line_one);
  endproperty
  a_quiet: assert property (p_quiet) else $error("wake moved alone");
  property p_rst;
    $rose(aresetn) |-> !wake_request && !ext_interrupt_line_one && !s_axi_bvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left state");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_wake: cover property ($rose(wake_request));
  c_irq: cover property ($rose(ext_interrupt_line_one));
endmodule // swsl_checker

bind swsl_top swsl_checker i_swsl_checker (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .port2_pins,
  .port3_pins, .port0_pins, .port2_data_reg_read, .port2_data_reg_write,
  .port3_data_reg_read, .port3_data_reg_write, .port2_mode_reg,
  .port0_input_mask, .wake_request, .ext_interrupt_line_one
);

// >>> sim/swsl_pins.sv
// Model of the external port pins feeding the wake inputs
`timescale 1ns/1ps
module swsl_pins (
  input logic aclk,
  input logic slow,
  input logic [13:0] cmd,
  output logic [13:0] pins
);
  logic ph = 1'b0;
  // A sluggish driver settles only on every other edge
  always @(posedge aclk)
  begin
    ph <= !ph;
    if (!slow || ph)
      pins <= cmd;
  end
endmodule // swsl_pins

// >>> sim/swsl_test.sv
// Self-checking bench for the wake-up source logic
`timescale 1ns/1ps
`include "swsl_defines.vh"
module swsl_test;
  localparam logic [11:0] st = `SWSL_IDX_STATUS;
  localparam logic [11:0] p2s = `SWSL_IDX_PORT2_SEL;
  localparam logic [11:0] cb = `SWSL_IDX_COMBO;
  localparam logic [11:0] p3s = `SWSL_IDX_PORT3_SEL;
  localparam logic [1:0] ok = `SWSL_RESP_OKAY;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, slow;
  logic s_axi_arvalid, s_axi_rready, lv, e;
  logic [3:0] s;
  logic [7:0] t;
  logic port2_data_reg_read, port2_data_reg_write;
  logic port3_data_reg_read, port3_data_reg_write;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [7:0] port2_mode_reg, port2_data_reg_value, p2;
  logic [3:0] port3_data_reg_value, p3;
  logic [1:0] port0_input_mask, p0;
  logic [2:0] c;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, wake_request, ext_interrupt_line_one;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] port2_pins;
  wire [3:0] port3_pins;
  wire [1:0] port0_pins;
  int n_fail, cmp_count, cyc;
  swsl_top i_swsl_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port2_pins, .port3_pins,
    .port0_pins, .port2_mode_reg, .port0_input_mask, .port2_data_reg_read,
    .port2_data_reg_write, .port2_data_reg_value, .port3_data_reg_read,
    .port3_data_reg_write, .port3_data_reg_value, .wake_request,
    .ext_interrupt_line_one
  );
  swsl_pins i_swsl_pins (
    .aclk, .slow, .cmd({p2, p3, p0}), .pins({port2_pins, port3_pins, port0_pins})
  );
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = !aclk;
  end
  task end_sim;
    begin
      if (n_fail == 0 && cmp_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      end_sim;
    end
  end
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    begin
      cmp_count++;
      if (g !== x)
      begin
        n_fail++;
        $display("unexpected %s expected %h seen %h", n, x, g);
      end
    end
  endtask
  task wr(input logic [11:0] i, input logic [7:0] d);
    logic a, w;
    begin
      @(posedge aclk);
      s_axi_awaddr <= {2'h0, i, 2'h0};
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      a = 1'b0;
      w = 1'b0;
      do
      begin
        @(posedge aclk);
        if (s_axi_awready === 1'b1 && !a)
        begin
          a = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (s_axi_wready === 1'b1 && !w)
        begin
          w = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
      end while (!(a && w));
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", ok, s_axi_bresp);
    end
  endtask
  task rd(input logic [11:0] i, input logic [31:0] x, input logic [1:0] r);
    begin
      @(posedge aclk);
      s_axi_araddr <= {2'h0, i, 2'h0};
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rdata", x, s_axi_rdata);
      chk("rresp", r, s_axi_rresp);
    end
  endtask
  task pa(input logic on3, input logic w, input logic [7:0] v);
    begin
      port2_data_reg_write <= !on3 && w;
      port2_data_reg_read <= !on3 && !w;
      port3_data_reg_write <= on3 && w;
      port3_data_reg_read <= on3 && !w;
      port2_data_reg_value <= v;
      port3_data_reg_value <= v[3:0];
      @(posedge aclk);
      {port2_data_reg_read, port2_data_reg_write} <= 2'h0;
      {port3_data_reg_read, port3_data_reg_write} <= 2'h0;
      @(posedge aclk);
    end
  endtask
  task ck(input logic ew, input logic ei);
    begin
      repeat (8) @(posedge aclk);
      chk("wake", ew, wake_request);
      chk("irq", ei, ext_interrupt_line_one);
    end
  endtask
  // Ignored pins are forced neutral; an all-ignored group gives no event
  function logic fx(input logic [2:0] k, input logic l);
    logic [8:0] g, m, v;
    begin
      case (k)
        3'h1, 3'h2: g = 9'h00F;
        3'h3, 3'h4: g = 9'h070;
        3'h5, 3'h6: g = 9'h1F0;
        3'h7: g = 9'h077;
        default: g = 9'h000;
      endcase
      // Pins selected for the compare path drop out of the group
      m = g & {port0_input_mask, ~s[3:1], port2_mode_reg[3:0] & ~t[3:0]};
      v = {p0, p3[3:1], p2[3:0]};
      if (k == 3'h2 || k == 3'h4 || k == 3'h5)
        fx = |m && (!(|(v & m)) == l);
      else
        fx = |m && (!(&(v | ~m)) == l);
    end
  endfunction
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, slow, port2_data_reg_read, port2_data_reg_write} = 4'h0;
    {port3_data_reg_read, port3_data_reg_write} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
    {port2_mode_reg, port2_data_reg_value, port3_data_reg_value} = 20'h0;
    {port0_input_mask, p2, p3, p0} = 16'hFFFF;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    aresetn = 1'b0;
    void'($urandom(20508));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(st, 0, ok);
    rd(p3s, 0, ok);
    rd(12'hF0B, 0, `SWSL_RESP_SLVERR);
    wr(p3s, 8'hF1);
    wr(st, 8'h10);
    p3 <= 4'hE;
    ck(1, 1);
    pa(1, 0, 8'h0);
    rd(st, 32'h14, ok);
    p3 <= 4'hF;
    ck(1, 1);
    pa(1, 1, 8'hF);
    rd(st, 32'h18, ok);
    ck(0, 0);
    pa(1, 1, 8'h0);
    ck(1, 1);
    wr(st, 8'h10);
    ck(0, 0);
    wr(st, 8'h00);
    p3 <= 4'hE;
    ck(1, 0);
    p3 <= 4'hF;
    p2 <= 8'hFE;
    port2_mode_reg <= 8'hFF;
    wr(p2s, 8'h01);
    ck(1, 0);
    pa(0, 1, 8'hFE);
    rd(st, 32'h02, ok);
    ck(0, 0);
    wr(st, 8'h00);
    ck(1, 0);
    wr(p2s, 8'h00);
    wr(st, 8'h10);
    for (int i = 0; i < 32; i++)
    begin
      c = i[2:0];
      lv = 1'($urandom);
      {p2, p3, p0} <= 14'($urandom);
      {port2_mode_reg, port0_input_mask} <= 10'($urandom);
      slow <= i[3];
      wr(cb, {1'b0, lv, 1'b1, c, 2'h0});
      // Mostly high pins selected, so the group result stays visible
      s = 4'($urandom) & (p3 | {3'h0, i[4]});
      t = 8'($urandom) & port2_mode_reg & (p2 | {7'h00, i[4]});
      wr(p3s, {4'hF, s});
      wr(p2s, t);
      e = fx(c, lv) | (|(s & ~p3)) | (|(t & ~p2));
      ck(e, e);
    end
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(st, 0, ok);
    end_sim;
  end
endmodule // swsl_test
